// ==== verilog/udfc_map.svh ====
/*
 * register offsets, field positions, reset values and timing counts for the
 * frame and endpoint command block.
 * assumes: included by bare name, inside or after the udfc package.
 */
`ifndef UDFC_MAP_SVH
`define UDFC_MAP_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define UDFC_ADDR_FRAME 4'h0
`define UDFC_ADDR_CMD 4'h4
`define UDFC_ADDR_INT_STATUS 4'h8
`define UDFC_ADDR_INT_MASK 4'hc
`define UDFC_ADDR_W 4

// ************************************************************
// frame register fields
// ************************************************************
`define UDFC_FRM_NUM_LSB 0
`define UDFC_FRM_NUM_W 11
`define UDFC_FRM_STAT_LSB 12
`define UDFC_FRM_CREATE_BIT 15
`define UDFC_FST_BEFORE 2'h0
`define UDFC_FST_VALID 2'h1
`define UDFC_FST_LOST 2'h2

// ************************************************************
// command register fields
// ************************************************************
`define UDFC_CMD_CODE_LSB 0
`define UDFC_CMD_EP_LSB 4
`define UDFC_CMD_ZLP_LSB 8
`define UDFC_CMD_TOGGLE_BIT 15
`define UDFC_CMD_RESET 32'h0000_0000
`define UDFC_EP_COUNT 4'h4

// ************************************************************
// interrupt status / mask bits
// ************************************************************
`define UDFC_INT_SOF_BIT 0
`define UDFC_INT_ZLP_BIT 1
`define UDFC_INT_LOST_BIT 2
`define UDFC_INT_W 3

// ************************************************************
// bus responses
// ************************************************************
`define UDFC_RESP_OKAY 2'h0
`define UDFC_RESP_SLVERR 2'h2

// ************************************************************
// timing
// ************************************************************
`define UDFC_CLK_MHZ 100
`define UDFC_FRAME_TIME_US 1000
`define UDFC_FRAME_CYCLES (`UDFC_FRAME_TIME_US * `UDFC_CLK_MHZ)

`endif

// ==== verilog/udfc_pkg.sv ====
/*
 * types shared by the frame and endpoint command block.
 * assumes: udfc_map.svh sits beside this file.
 */
package udfc_pkg;
`include "udfc_map.svh"

   typedef enum logic [3:0] {
      UDFC_CMD_RSVD0 = 4'h0,
      UDFC_CMD_SETUP_FIN = 4'h1,
      UDFC_CMD_FORCE_DATA0 = 4'h2,
      UDFC_CMD_ENDPOINT_RESET_CMD = 4'h3,
      UDFC_CMD_EP_HALT = 4'h4,
      UDFC_CMD_EP_INVALIDATE = 4'h5,
      UDFC_CMD_RSVD6 = 4'h6,
      UDFC_CMD_ENDPOINT_DISABLE_CMD = 4'h7,
      UDFC_CMD_ENDPOINT_ENABLE_CMD = 4'h8,
      UDFC_CMD_INVALIDATE_ALL = 4'h9,
      UDFC_CMD_BUS_READY = 4'ha,
      UDFC_CMD_SETUP_RECEIVED = 4'hb,
      UDFC_CMD_END_OF_PACKET = 4'hc,
      UDFC_CMD_FIFO_CLEAR = 4'hd,
      UDFC_CMD_SEND_ZERO_LENGTH = 4'he,
      UDFC_CMD_RSVDF = 4'hf
   } udfc_cmd_t;

   typedef enum logic [1:0] {
      UDFC_FS_LOST,
      UDFC_FS_VALID,
      UDFC_FS_BEFORE
   } udfc_fstate_t;

endpackage : udfc_pkg

// ==== verilog/udfc_frm_if.sv ====
/*
 * carries start-of-frame events in and the frame number state out between
 * the register block and the frame tracker.
 * assumes: both ends run on the same clock.
 */
`timescale 1ns/100ps
interface udfc_frm_if;
   logic sof_pulse;
   logic [10:0] sof_frame;
   logic suspend;
   logic create_sof;
   logic [1:0] status;
   logic [10:0] frame;
   logic lost_pulse;

   modport tracker (
      input sof_pulse,
      input sof_frame,
      input suspend,
      input create_sof,
      output status,
      output frame,
      output lost_pulse
   );

   modport owner (
      output sof_pulse,
      output sof_frame,
      output suspend,
      output create_sof,
      input status,
      input frame,
      input lost_pulse
   );
endinterface : udfc_frm_if

// ==== verilog/udfc_frame_track.sv ====
/*
 * frame number capture and frame number state tracking.
 * assumes: sof and suspend come from logic on aclk, no synchroniser needed.
 */
`timescale 1ns/100ps
module udfc_frame_track #(
   parameter int unsigned FRAME_CYCLES = `UDFC_FRAME_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   udfc_frm_if.tracker fi
);
   udfc_pkg::udfc_fstate_t st_r, st_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic [10:0] frame_r, frame_nxt;
   logic [1:0] code_r, code_nxt;
   logic lost_r, lost_nxt;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      frame_nxt = frame_r;
      lost_nxt = 1'b0;
      if (fi.suspend) begin
         if (st_r != udfc_pkg::UDFC_FS_LOST) begin
            lost_nxt = 1'b1;
         end
         st_nxt = udfc_pkg::UDFC_FS_LOST;
         cnt_nxt = 32'h0;
      end else if (fi.sof_pulse) begin
         frame_nxt = fi.sof_frame;
         st_nxt = udfc_pkg::UDFC_FS_VALID;
         cnt_nxt = 32'h0;
      end else if (fi.create_sof && st_r != udfc_pkg::UDFC_FS_LOST) begin
         if (cnt_r == FRAME_CYCLES - 1) begin
            cnt_nxt = 32'h0;
            if (st_r == udfc_pkg::UDFC_FS_VALID) begin
               st_nxt = udfc_pkg::UDFC_FS_BEFORE;
            end else begin
               st_nxt = udfc_pkg::UDFC_FS_LOST;
               lost_nxt = 1'b1;
            end
         end else begin
            cnt_nxt = cnt_r + 32'h1;
         end
      end
      unique case (st_nxt)
         udfc_pkg::UDFC_FS_VALID: code_nxt = `UDFC_FST_VALID;
         udfc_pkg::UDFC_FS_BEFORE: code_nxt = `UDFC_FST_BEFORE;
         udfc_pkg::UDFC_FS_LOST: code_nxt = `UDFC_FST_LOST;
         default: code_nxt = `UDFC_FST_LOST;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= udfc_pkg::UDFC_FS_LOST;
         cnt_r <= 32'h0;
         frame_r <= 11'h000;
         code_r <= `UDFC_FST_LOST;
         lost_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         frame_r <= frame_nxt;
         code_r <= code_nxt;
         lost_r <= lost_nxt;
      end
   end

   assign fi.status = code_r;
   assign fi.frame = frame_r;
   assign fi.lost_pulse = lost_r;
endmodule : udfc_frame_track

// ==== verilog/udfc_top.sv ====
/*
 * frame register, endpoint command register and interrupt logic of a
 * full-speed usb device controller, reached over axi4-lite.
 * assumes: packet-engine strobes arrive on aclk; one command consumer.
 */
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module udfc_top #(
   parameter int unsigned FRAME_CYCLES = `UDFC_FRAME_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sof_rx,
   input wire logic [10:0] sof_frame_in,
   input wire logic bus_suspend,
   input wire logic zlp_rx,
   input wire logic [3:0] zlp_ep_in,
   input wire logic intin_no_handshake,
   output logic cmd_valid,
   output logic [3:0] cmd_code,
   output logic [3:0] target_endpoint,
   output logic data_toggle_advance,
   output logic irq
);
   // ************************************************************
   // frame tracker
   // ************************************************************
   udfc_frm_if frm ();

   logic create_sof_r, create_sof_nxt;

   assign frm.sof_pulse = sof_rx;
   assign frm.sof_frame = sof_frame_in;
   assign frm.suspend = bus_suspend;
   assign frm.create_sof = create_sof_r;

   udfc_frame_track #(
      .FRAME_CYCLES(FRAME_CYCLES)
   ) u_track (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .fi(frm)
   );

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : strb_merge

   function automatic logic addr_mapped(input logic [3:0] a);
      return (a == `UDFC_ADDR_FRAME) || (a == `UDFC_ADDR_CMD) ||
             (a == `UDFC_ADDR_INT_STATUS) || (a == `UDFC_ADDR_INT_MASK);
   endfunction : addr_mapped

   function automatic logic code_legal(input logic [3:0] c);
      return !(c == udfc_pkg::UDFC_CMD_RSVD0 || c == udfc_pkg::UDFC_CMD_RSVD6 ||
               c == udfc_pkg::UDFC_CMD_RSVDF);
   endfunction : code_legal

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic aw_held_r, aw_held_nxt;
   logic w_held_r, w_held_nxt;
   logic [3:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic wr_fire;
   logic rd_fire;

   // core state read by the bus mux
   logic [3:0] ep_r;
   logic [3:0] code_r;
   logic toggle_en_r;
   logic [3:0] zlp_ep_r;
   logic [`UDFC_INT_W-1:0] int_stat_r;
   logic [`UDFC_INT_W-1:0] int_mask_r;

   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      wr_fire = 1'b0;
      rd_fire = 1'b0;
      if (s_axi_awvalid && awready_r) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      // address and data both held: commit, answer next cycle
      if (aw_held_r && w_held_r && !bvalid_r) begin
         wr_fire = 1'b1;
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = addr_mapped(awaddr_r) ? `UDFC_RESP_OKAY : `UDFC_RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         rd_fire = 1'b1;
         rvalid_nxt = 1'b1;
         rresp_nxt = `UDFC_RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         unique case (s_axi_araddr)
            `UDFC_ADDR_FRAME: begin
               rdata_nxt[`UDFC_FRM_NUM_LSB +: `UDFC_FRM_NUM_W] = frm.frame;
               rdata_nxt[`UDFC_FRM_STAT_LSB +: 2] = frm.status;
               rdata_nxt[`UDFC_FRM_CREATE_BIT] = create_sof_r;
            end
            `UDFC_ADDR_CMD: begin
               rdata_nxt[`UDFC_CMD_CODE_LSB +: 4] = code_r;
               rdata_nxt[`UDFC_CMD_EP_LSB +: 4] = ep_r;
               rdata_nxt[`UDFC_CMD_ZLP_LSB +: 4] = zlp_ep_r;
               rdata_nxt[`UDFC_CMD_TOGGLE_BIT] = toggle_en_r;
            end
            `UDFC_ADDR_INT_STATUS: rdata_nxt[`UDFC_INT_W-1:0] = int_stat_r;
            `UDFC_ADDR_INT_MASK: rdata_nxt[`UDFC_INT_W-1:0] = int_mask_r;
            default: rresp_nxt = `UDFC_RESP_SLVERR;
         endcase
      end
      // one write and one read in flight at most
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `UDFC_RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= `UDFC_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (ce) begin
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
      end
   end

   // ************************************************************
   // registers, commands and interrupts
   // ************************************************************
   logic [3:0] ep_nxt, code_nxt, zlp_ep_nxt;
   logic toggle_en_nxt;
   logic [`UDFC_INT_W-1:0] int_stat_nxt, int_mask_nxt, int_set;
   logic cmd_valid_r, cmd_valid_nxt;
   logic [3:0] cmd_code_r, cmd_code_nxt;
   logic [3:0] tgt_ep_r, tgt_ep_nxt;
   logic tog_adv_r, tog_adv_nxt;
   logic irq_r, irq_nxt;
   logic [31:0] cmd_word;

   always_comb begin
      ep_nxt = ep_r;
      code_nxt = code_r;
      toggle_en_nxt = toggle_en_r;
      zlp_ep_nxt = zlp_ep_r;
      create_sof_nxt = create_sof_r;
      int_mask_nxt = int_mask_r;
      int_stat_nxt = int_stat_r;
      cmd_valid_nxt = 1'b0;
      cmd_code_nxt = cmd_code_r;
      tgt_ep_nxt = tgt_ep_r;
      cmd_word = 32'h0000_0000;
      cmd_word[`UDFC_CMD_CODE_LSB +: 4] = code_r;
      cmd_word[`UDFC_CMD_EP_LSB +: 4] = ep_r;
      cmd_word[`UDFC_CMD_TOGGLE_BIT] = toggle_en_r;
      cmd_word = strb_merge(cmd_word, wdata_r, wstrb_r);
      if (wr_fire) begin
         unique case (awaddr_r)
            `UDFC_ADDR_FRAME: begin
               if (wstrb_r[1]) begin
                  create_sof_nxt = wdata_r[`UDFC_FRM_CREATE_BIT];
               end
            end
            `UDFC_ADDR_CMD: begin
               toggle_en_nxt = cmd_word[`UDFC_CMD_TOGGLE_BIT];
               ep_nxt = cmd_word[`UDFC_CMD_EP_LSB +: 4];
               code_nxt = cmd_word[`UDFC_CMD_CODE_LSB +: 4];
               if (wstrb_r[0] && code_legal(code_nxt) && ep_nxt < `UDFC_EP_COUNT) begin
                  cmd_valid_nxt = 1'b1;
                  cmd_code_nxt = code_nxt;
                  tgt_ep_nxt = ep_nxt;
               end
            end
            `UDFC_ADDR_INT_MASK: begin
               if (wstrb_r[0]) begin
                  int_mask_nxt = wdata_r[`UDFC_INT_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
      if (zlp_rx) begin
         zlp_ep_nxt = zlp_ep_in;
      end
      int_set = '0;
      int_set[`UDFC_INT_SOF_BIT] = sof_rx;
      int_set[`UDFC_INT_ZLP_BIT] = zlp_rx;
      int_set[`UDFC_INT_LOST_BIT] = frm.lost_pulse;
      // read clears, but a fresh event in the same cycle survives
      if (rd_fire && s_axi_araddr == `UDFC_ADDR_INT_STATUS) begin
         int_stat_nxt = '0;
      end
      int_stat_nxt = int_stat_nxt | int_set;
      irq_nxt = |(int_stat_nxt & int_mask_nxt);
      tog_adv_nxt = intin_no_handshake && toggle_en_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep_r <= 4'h0;
         code_r <= 4'h0;
         toggle_en_r <= 1'b0;
         zlp_ep_r <= 4'h0;
         create_sof_r <= 1'b0;
         int_stat_r <= '0;
         int_mask_r <= '0;
         cmd_valid_r <= 1'b0;
         cmd_code_r <= 4'h0;
         tgt_ep_r <= 4'h0;
         tog_adv_r <= 1'b0;
         irq_r <= 1'b0;
      end else if (ce) begin
         ep_r <= ep_nxt;
         code_r <= code_nxt;
         toggle_en_r <= toggle_en_nxt;
         zlp_ep_r <= zlp_ep_nxt;
         create_sof_r <= create_sof_nxt;
         int_stat_r <= int_stat_nxt;
         int_mask_r <= int_mask_nxt;
         cmd_valid_r <= cmd_valid_nxt;
         cmd_code_r <= cmd_code_nxt;
         tgt_ep_r <= tgt_ep_nxt;
         tog_adv_r <= tog_adv_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign cmd_valid = cmd_valid_r;
   assign cmd_code = cmd_code_r;
   assign target_endpoint = tgt_ep_r;
   assign data_toggle_advance = tog_adv_r;
   assign irq = irq_r;
endmodule : udfc_top

// ==== verification/udfc_host_model.sv ====
/*
 * host side model: sof, zero-length packets, missed handshakes.
 * assumes: called from the bench; all strobes last one aclk cycle.
 */
`timescale 1ns/100ps
module udfc_host_model (
   input wire logic aclk,
   output logic sof_rx,
   output logic [10:0] sof_frame_in,
   output logic bus_suspend,
   output logic zlp_rx,
   output logic [3:0] zlp_ep_in,
   output logic intin_no_handshake
);
   initial begin
      sof_rx = 1'b0;
      sof_frame_in = 11'h0;
      bus_suspend = 1'b0;
      zlp_rx = 1'b0;
      zlp_ep_in = 4'h0;
      intin_no_handshake = 1'b0;
   end

   // qualifiers inverted after the strobe so stale values never look valid
   task automatic send_sof(input logic [10:0] f);
      @(posedge aclk);
      sof_rx <= 1'b1;
      sof_frame_in <= f;
      @(posedge aclk);
      sof_rx <= 1'b0;
      sof_frame_in <= ~f;
   endtask : send_sof

   task automatic send_zlp(input logic [3:0] ep);
      @(posedge aclk);
      zlp_rx <= 1'b1;
      zlp_ep_in <= ep;
      @(posedge aclk);
      zlp_rx <= 1'b0;
      zlp_ep_in <= ~ep;
   endtask : send_zlp

   task automatic no_handshake;
      @(posedge aclk);
      intin_no_handshake <= 1'b1;
      @(posedge aclk);
      intin_no_handshake <= 1'b0;
   endtask : no_handshake

   task automatic set_suspend(input logic s);
      @(posedge aclk);
      bus_suspend <= s;
      repeat (2) @(posedge aclk);
   endtask : set_suspend
endmodule : udfc_host_model

// ==== verification/udfc_checker.sv ====
/*
 * port assertions for udfc_top.
 * assumes: one aclk domain; ce held high.
 */
`timescale 1ns/100ps
`include "udfc_map.svh"
module udfc_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic sof_rx,
   input wire logic [10:0] sof_frame_in,
   input wire logic zlp_rx,
   input wire logic [3:0] zlp_ep_in,
   input wire logic intin_no_handshake,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_code,
   input wire logic [3:0] target_endpoint,
   input wire logic data_toggle_advance
);
   // ************************************************************
   // shadows of bus and link
   // ************************************************************
   logic [3:0] ra_r, ra_nxt, zlp_r, zlp_nxt;
   logic [10:0] frm_r, frm_nxt;

   always_comb begin
      ra_nxt = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_r;
      zlp_nxt = zlp_rx ? zlp_ep_in : zlp_r;
      frm_nxt = sof_rx ? sof_frame_in : frm_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ra_r <= 4'h0;
         zlp_r <= 4'h0;
         frm_r <= 11'h0;
      end else begin
         ra_r <= ra_nxt;
         zlp_r <= zlp_nxt;
         frm_r <= frm_nxt;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   frame_capture_a: assert property ($rose(s_axi_rvalid) && ra_r == `UDFC_ADDR_FRAME
      |-> s_axi_rdata[10:0] == $past(frm_r)) else $error("frame number not captured");
   frame_state_a: assert property ($rose(s_axi_rvalid) && ra_r == `UDFC_ADDR_FRAME
      |-> s_axi_rdata[13:12] != 2'h3 && !s_axi_rdata[11]) else $error("bad frame state");
   toggle_cause_a: assert property (data_toggle_advance |-> $past(intin_no_handshake))
      else $error("toggle advance without missed handshake");
   zlp_source_a: assert property ($rose(s_axi_rvalid) && ra_r == `UDFC_ADDR_CMD
      |-> s_axi_rdata[11:8] == $past(zlp_r)) else $error("zero-length endpoint lost");
   cmd_endpoint_a: assert property (cmd_valid |-> target_endpoint < `UDFC_EP_COUNT)
      else $error("command issued to missing endpoint");
   cmd_reserved_a: assert property (cmd_valid |-> !(cmd_code inside {4'h0, 4'h6, 4'hf}))
      else $error("reserved command issued");
   upper_bits_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("unused bits not zero");
   cmd_commit_a: assert property (cmd_valid |-> $rose(s_axi_bvalid))
      else $error("command without write commit");
   cmd_single_a: assert property (cmd_valid |=> !cmd_valid [*2])
      else $error("command issued twice");
endmodule : udfc_checker

bind udfc_top udfc_checker i_udfc_checker (.*);

// ==== verification/udfc_top_bench.sv ====
/*
 * register level bench for udfc_top over axi4-lite, with the host model.
 * assumes: udfc package and map header compiled first.
 */
`timescale 1ns/100ps
`include "udfc_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module udfc_top_bench;
   logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [2:0] prot;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, zlp_ep_in, cmd_code, target_endpoint;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic sof_rx, bus_suspend, zlp_rx, intin_no_handshake, cmd_valid, data_toggle_advance, irq;
   logic [10:0] sof_frame_in;
   logic [7:0] last_cmd;
   int bad_count, comparisons, cmd_n, tog_n, cyc, n0;

   // short frame so timeouts show within a hundred cycles
   udfc_top #(.FRAME_CYCLES(40)) i_udfc_top (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(prot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(prot),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .sof_rx(sof_rx), .sof_frame_in(sof_frame_in), .bus_suspend(bus_suspend),
      .zlp_rx(zlp_rx), .zlp_ep_in(zlp_ep_in), .intin_no_handshake(intin_no_handshake),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .target_endpoint(target_endpoint),
      .data_toggle_advance(data_toggle_advance), .irq(irq)
   );

   udfc_host_model i_udfc_host_model (
      .aclk(aclk), .sof_rx(sof_rx), .sof_frame_in(sof_frame_in), .bus_suspend(bus_suspend),
      .zlp_rx(zlp_rx), .zlp_ep_in(zlp_ep_in), .intin_no_handshake(intin_no_handshake)
   );

   always #5 aclk = ~aclk;

   // ************************************************************
   // monitors, hang guard, closing report
   // ************************************************************
   always @(posedge aclk) begin
      cyc++;
      if (cmd_valid === 1'b1) begin
         cmd_n++;
         last_cmd = {cmd_code, target_endpoint};
      end
      if (data_toggle_advance === 1'b1) tog_n++;
      if (cyc == 5000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      if (bad_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict

   // ************************************************************
   // bus tasks
   // ************************************************************
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   task automatic expect_rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      axi_read(a, d);
      `CHK(d, e)
   endtask : expect_rd

   task automatic settle;
      repeat (3) @(posedge aclk);
   endtask : settle

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {ce, prot, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 9'h100;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      expect_rd(`UDFC_ADDR_FRAME, 32'h0000_2000);
      expect_rd(`UDFC_ADDR_CMD, `UDFC_CMD_RESET);
      expect_rd(4'h2, 32'h0);
      i_udfc_host_model.send_sof(11'h7ff);
      axi_write(`UDFC_ADDR_FRAME, 32'hffff_ffff, 4'hf);
      expect_rd(`UDFC_ADDR_FRAME, 32'h0000_97ff);
      i_udfc_host_model.send_sof(11'h2a5);
      repeat (50) @(posedge aclk);
      expect_rd(`UDFC_ADDR_FRAME, 32'h0000_82a5);
      repeat (40) @(posedge aclk);
      expect_rd(`UDFC_ADDR_FRAME, 32'h0000_a2a5);
      axi_write(`UDFC_ADDR_FRAME, 32'h0, 4'hf);
      i_udfc_host_model.send_sof(11'h001);
      i_udfc_host_model.set_suspend(1'b1);
      expect_rd(`UDFC_ADDR_FRAME, 32'h0000_2001);
      i_udfc_host_model.set_suspend(1'b0);
      axi_read(`UDFC_ADDR_INT_STATUS, rd);
      axi_write(`UDFC_ADDR_INT_MASK, 32'h0000_0002, 4'hf);
      i_udfc_host_model.send_sof(11'h010);
      settle();
      `CHK(irq, 1'b0)
      i_udfc_host_model.send_zlp(4'h3);
      settle();
      `CHK(irq, 1'b1)
      expect_rd(`UDFC_ADDR_INT_STATUS, 32'h0000_0003);
      settle();
      `CHK(irq, 1'b0)
      expect_rd(`UDFC_ADDR_CMD, 32'h0000_0300);
      i_udfc_host_model.send_zlp(4'h1);
      axi_write(`UDFC_ADDR_CMD, 32'h0000_8f00, 4'hf);
      expect_rd(`UDFC_ADDR_CMD, 32'h0000_8100);
      i_udfc_host_model.no_handshake();
      settle();
      `CHK(tog_n, 1)
      axi_write(`UDFC_ADDR_CMD, 32'h0, 4'hf);
      i_udfc_host_model.no_handshake();
      settle();
      `CHK(tog_n, 1)
      for (int c = 0; c < 16; c++) begin
         n0 = cmd_n;
         axi_write(`UDFC_ADDR_CMD, {24'h0, 4'h2, c[3:0]}, 4'h1);
         settle();
         `CHK(cmd_n - n0, (c inside {0, 6, 15}) ? 0 : 1)
         if (!(c inside {0, 6, 15})) `CHK(last_cmd, {c[3:0], 4'h2})
      end
      n0 = cmd_n;
      axi_write(`UDFC_ADDR_CMD, 32'h0000_0041, 4'hf);
      axi_write(`UDFC_ADDR_CMD, 32'h0000_0031, 4'h2);
      axi_write(`UDFC_ADDR_CMD, 32'h0000_0031, 4'hf);
      axi_write(`UDFC_ADDR_CMD, 32'h0000_0031, 4'hf);
      settle();
      `CHK(cmd_n - n0, 2)
      expect_rd(`UDFC_ADDR_CMD, 32'h0000_0131);
      print_verdict();
   end
endmodule : udfc_top_bench
